// ==== rtl/mmso_pkg.sv ====
// package: encodings, address layout and reset values of the move/multiply/stack executor
package mmso_pkg;
  // q phases of one instruction cycle
  localparam int         Q_PER_CYCLE   = 4;
  localparam logic [1:0] Q1            = 2'h0;
  localparam logic [1:0] Q2            = 2'h1;
  localparam logic [1:0] Q3            = 2'h2;
  localparam logic [1:0] Q4            = 2'h3;
  // opcode fields
  localparam logic [3:0] MOVE_FIRST_HI = 4'hc;
  localparam logic [3:0] MOVE_SECND_HI = 4'hf;
  localparam logic [6:0] ACC_TO_FILE   = 7'h37;
  localparam logic [6:0] NEGATE_FILE   = 7'h36;
  localparam logic [6:0] FILE_MULTIPLY = 7'h01;
  localparam logic [7:0] LIT_MULTIPLY  = 8'h0d;
  localparam logic [7:0] LIT_TO_ACC    = 8'h0e;
  localparam logic [7:0] BANK_LIT_LOAD = 8'h01;
  localparam logic [15:0] NO_OPERATION = 16'h0000;
  localparam logic [15:0] STACK_POP    = 16'h0006;
  localparam logic [15:0] STACK_PUSH   = 16'h0005;
  // access bank split and the accumulator's place in the data space
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
  localparam logic [3:0]  ACCESS_LOWPG = 4'h0;
  localparam logic [3:0]  ACCESS_HIPG  = 4'hf;
  localparam logic [11:0] ACC_ADDR_DEF = 12'hfe8;
  localparam logic [20:0] PUSH_STEP    = 21'h000002;
  // reset values
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [7:0]  BANK_RST     = 8'h00;
  localparam logic [7:0]  PROD_RST     = 8'h00;
  localparam logic [4:0]  FLAGS_RST    = 5'h00;
  // flag positions in the status vector
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;

  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_MOVE   = 4'h1,
    OP_ACCWR  = 4'h2,
    OP_NEG    = 4'h3,
    OP_MULF   = 4'h4,
    OP_MULL   = 4'h5,
    OP_LITACC = 4'h6,
    OP_BANK   = 4'h7,
    OP_POP    = 4'h8,
    OP_PUSH   = 4'h9
  } mmso_op_type;

  typedef enum logic [0:0] {
    EXEC_FIRST  = 1'b0,
    MOVE_SECOND = 1'b1
  } mmso_state_type;
endpackage

// ==== rtl/mmso_alu_if.sv ====
// interface: operands and results between the executor and its arithmetic unit
`timescale 1ns/1ps
interface mmso_alu_if;
  logic [7:0]  accOp;
  logic [7:0]  otherOp;
  logic [15:0] product;
  logic [7:0]  negResult;
  logic [4:0]  negFlags;
  modport core (output accOp, otherOp, input product, negResult, negFlags);
  modport unit (input accOp, otherOp, output product, negResult, negFlags);
endinterface

// ==== rtl/mmso_alu.sv ====
// arithmetic unit: unsigned 8x8 multiply and two's complement negate with flags
`timescale 1ns/1ps
module mmso_alu
  import mmso_pkg::*;
(
  mmso_alu_if.unit alu
);
  // product of accumulator and literal or file byte, never signed
  assign alu.product = 16'(alu.accOp) * 16'(alu.otherOp);

  // negate is 0 - f, so carry means no borrow, i.e. only f == 0
  always_comb
  begin
    alu.negResult              = 8'(~alu.otherOp + 8'h01);
    alu.negFlags               = FLAGS_RST;
    alu.negFlags[FLAG_C]       = (alu.otherOp == 8'h00);
    alu.negFlags[FLAG_DC]      = (alu.otherOp[3:0] == 4'h0);
    alu.negFlags[FLAG_Z]       = (alu.negResult == 8'h00);
    alu.negFlags[FLAG_OV]      = (alu.otherOp == 8'h80);
    alu.negFlags[FLAG_N]       = alu.negResult[7];
  end
endmodule

// ==== rtl/mmso_move_mul_core.sv ====
// executor for moves, literal loads, multiplies, negate, no-op and return-stack ops
`timescale 1ns/1ps
module mmso_move_mul_core
  import mmso_pkg::*;
#(
  parameter logic [11:0] ACC_ADDR = ACC_ADDR_DEF
)(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] instrWord,
  input  wire logic [20:0] progCounter,
  input  wire logic [7:0]  dataRdData,
  output logic      [1:0]  qPhase,
  output logic      [11:0] dataAddr,
  output logic             dataRdEn,
  output logic             dataWrEn,
  output logic      [7:0]  dataWrData,
  output logic      [7:0]  accumulator,
  output logic      [7:0]  bankSelect,
  output logic      [7:0]  productHigh,
  output logic      [7:0]  productLow,
  output logic      [4:0]  statusFlags,
  output logic             stackPush,
  output logic             stackPop,
  output logic      [20:0] stackPushValue
);
  // the accumulator is served from a register that is only mapped into the top page
  if (ACC_ADDR[11:8] != ACCESS_HIPG)
  begin : gAccPageCheck
    $error("accumulator must sit in the top page of the data space");
  end

  logic [1:0]     qPhase_r;
  mmso_state_type state_r;
  mmso_op_type    op_r;
  logic [15:0]    instr_r;
  logic [7:0]     operand_r;
  logic [7:0]     moveData_r;
  logic [11:0]    dataAddr_r;
  logic           dataRdEn_r;
  logic           dataWrEn_r;
  logic [7:0]     dataWrData_r;
  logic [7:0]     accum_r;
  logic [7:0]     bankSel_r;
  logic [7:0]     prodHigh_r;
  logic [7:0]     prodLow_r;
  logic [4:0]     flags_r;
  logic           stackPush_r;
  logic           stackPop_r;
  logic [20:0]    stackPushValue_r;
  logic [11:0]    fileAddr;
  logic           wrNeeded;
  logic [7:0]     wrValue;
  mmso_op_type    decoded;

  mmso_alu_if aluBus ();
  mmso_alu alu_inst (.alu(aluBus.unit));

  ////////////////////////////////////////////////////////////////////////////////
  // decode and operand routing

  // anything outside this group, and a lone 1111 word, falls to OP_NONE
  always_comb
  begin
    decoded = OP_NONE;
    if (instrWord[15:12] == MOVE_FIRST_HI)
      decoded = OP_MOVE;
    else if (instrWord[15:9] == ACC_TO_FILE)
      decoded = OP_ACCWR;
    else if (instrWord[15:9] == NEGATE_FILE)
      decoded = OP_NEG;
    else if (instrWord[15:9] == FILE_MULTIPLY)
      decoded = OP_MULF;
    else if (instrWord[15:8] == LIT_MULTIPLY)
      decoded = OP_MULL;
    else if (instrWord[15:8] == LIT_TO_ACC)
      decoded = OP_LITACC;
    else if (instrWord[15:8] == BANK_LIT_LOAD)
      decoded = OP_BANK;
    else if (instrWord == STACK_POP)
      decoded = OP_POP;
    else if (instrWord == STACK_PUSH)
      decoded = OP_PUSH;
  end

  // only the low nibble of bank select reaches the 12-bit address
  always_comb
  begin
    if (instr_r[8])
      fileAddr = {bankSel_r[3:0], instr_r[7:0]};
    else if (instr_r[7:0] < ACCESS_SPLIT)
      fileAddr = {ACCESS_LOWPG, instr_r[7:0]};
    else
      fileAddr = {ACCESS_HIPG, instr_r[7:0]};
  end

  assign aluBus.accOp   = accum_r;
  assign aluBus.otherOp = (op_r == OP_MULL) ? instr_r[7:0] : operand_r;

  // write-back of the current Q4: move destination, accumulator store or negate
  always_comb
  begin
    wrNeeded = (state_r == MOVE_SECOND) || (op_r == OP_ACCWR) || (op_r == OP_NEG);
    wrValue  = aluBus.negResult;
    if (state_r == MOVE_SECOND)
      wrValue = moveData_r;
    else if (op_r == OP_ACCWR)
      wrValue = accum_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // phase divider and sequencing

  // four clocks per instruction cycle; each phase is one clock
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      qPhase_r <= Q1;
    else
      qPhase_r <= 2'(qPhase_r + 2'h1);
  end

  // the second move word is never decoded, so its 1111 top nibble is not a no-op here
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      instr_r <= NO_OPERATION;
      op_r    <= OP_NONE;
    end
    else if (qPhase_r == Q1)
    begin
      instr_r <= instrWord;
      if (state_r == EXEC_FIRST)
        op_r <= decoded;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= EXEC_FIRST;
    else if (qPhase_r == Q4)
    begin
      unique case (state_r)
        EXEC_FIRST:  state_r <= (op_r == OP_MOVE) ? MOVE_SECOND : EXEC_FIRST;
        MOVE_SECOND: state_r <= EXEC_FIRST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data memory strobes

  // address set in Q2 stays for the write in Q4 of the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dataAddr_r <= 12'h000;
      dataRdEn_r <= 1'b0;
    end
    else
    begin
      dataRdEn_r <= 1'b0;
      if (qPhase_r == Q2)
      begin
        if (state_r == MOVE_SECOND)
        begin
          dataAddr_r <= instr_r[11:0]; // dummy read of destination
          dataRdEn_r <= 1'b1;
        end
        else if (op_r == OP_MOVE)
        begin
          dataAddr_r <= instr_r[11:0];
          dataRdEn_r <= 1'b1;
        end
        else if (op_r inside {OP_ACCWR, OP_NEG, OP_MULF})
        begin
          dataAddr_r <= fileAddr;
          dataRdEn_r <= 1'b1;
        end
      end
    end
  end

  // the accumulator is not in memory, so its address is served from accum_r
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      operand_r  <= 8'h00;
      moveData_r <= 8'h00;
    end
    else if (qPhase_r == Q3)
    begin
      operand_r <= (dataAddr_r == ACC_ADDR) ? accum_r : dataRdData;
      if (state_r == EXEC_FIRST && op_r == OP_MOVE)
        moveData_r <= (dataAddr_r == ACC_ADDR) ? accum_r : dataRdData;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dataWrEn_r   <= 1'b0;
      dataWrData_r <= 8'h00;
    end
    else
    begin
      dataWrEn_r <= 1'b0;
      if (qPhase_r == Q4 && wrNeeded && dataAddr_r != ACC_ADDR)
      begin
        dataWrEn_r   <= 1'b1;
        dataWrData_r <= wrValue;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // architectural registers, all updated at Q4

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      accum_r <= ACC_RST;
    else if (qPhase_r == Q4)
    begin
      if (wrNeeded && dataAddr_r == ACC_ADDR)
        accum_r <= wrValue;
      else if (state_r == EXEC_FIRST && op_r == OP_LITACC)
        accum_r <= instr_r[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bankSel_r <= BANK_RST;
    else if (qPhase_r == Q4 && state_r == EXEC_FIRST && op_r == OP_BANK)
      bankSel_r <= instr_r[7:0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prodHigh_r <= PROD_RST;
      prodLow_r  <= PROD_RST;
    end
    else if (qPhase_r == Q4 && state_r == EXEC_FIRST && op_r inside {OP_MULL, OP_MULF})
    begin
      prodHigh_r <= aluBus.product[15:8];
      prodLow_r  <= aluBus.product[7:0];
    end
  end

  // only negate touches the flags; moves, stores and multiplies leave them
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_r <= FLAGS_RST;
    else if (qPhase_r == Q4 && state_r == EXEC_FIRST && op_r == OP_NEG)
      flags_r <= aluBus.negFlags;
  end

  // pop and push are one-clock strobes to the return stack outside
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stackPush_r      <= 1'b0;
      stackPop_r       <= 1'b0;
      stackPushValue_r <= 21'h000000;
    end
    else
    begin
      stackPush_r <= qPhase_r == Q4 && state_r == EXEC_FIRST && op_r == OP_PUSH;
      stackPop_r  <= qPhase_r == Q4 && state_r == EXEC_FIRST && op_r == OP_POP;
      if (qPhase_r == Q4 && state_r == EXEC_FIRST && op_r == OP_PUSH)
        stackPushValue_r <= 21'(progCounter + PUSH_STEP);
    end
  end

  assign qPhase         = qPhase_r;
  assign dataAddr       = dataAddr_r;
  assign dataRdEn       = dataRdEn_r;
  assign dataWrEn       = dataWrEn_r;
  assign dataWrData     = dataWrData_r;
  assign accumulator    = accum_r;
  assign bankSelect     = bankSel_r;
  assign productHigh    = prodHigh_r;
  assign productLow     = prodLow_r;
  assign statusFlags    = flags_r;
  assign stackPush      = stackPush_r;
  assign stackPop       = stackPop_r;
  assign stackPushValue = stackPushValue_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence moveFirstQ4;
    qPhase_r == Q4 && state_r == EXEC_FIRST && op_r == OP_MOVE;
  endsequence
  // the write strobe shows in the clock after the second Q4 edge
  sequence moveWriteDone;
    ##5 ((dataWrEn_r && dataWrData_r == moveData_r)
      || (dataAddr_r == ACC_ADDR && accum_r == moveData_r));
  endsequence

  move_two_cycle_a: assert property (moveFirstQ4 |=> (state_r == MOVE_SECOND) [*4] ##1
    state_r == EXEC_FIRST) else $error("move did not take exactly two cycles");
  move_write_a: assert property (moveFirstQ4 |-> moveWriteDone)
    else $error("move destination not written at second Q4");
  move_flags_a: assert property (state_r == MOVE_SECOND |-> $stable(flags_r))
    else $error("flags changed during move");
  access_bank_a: assert property (qPhase_r == Q2 && state_r == EXEC_FIRST
    && op_r == OP_NEG && !instr_r[8] |=> dataAddr_r ==
    {(instr_r[7:0] < ACCESS_SPLIT) ? ACCESS_LOWPG : ACCESS_HIPG, instr_r[7:0]})
    else $error("access bank not selected");
  neg_value_a: assert property (dataWrEn_r && $past(op_r) == OP_NEG
    && $past(state_r) == EXEC_FIRST |-> 8'(dataWrData_r + operand_r) == 8'h00)
    else $error("negate result wrong");
  neg_zero_a: assert property (qPhase_r == Q4 && state_r == EXEC_FIRST && op_r == OP_NEG
    |=> flags_r[FLAG_Z] == (operand_r == 8'h00)) else $error("negate zero flag wrong");
  mul_product_a: assert property (qPhase_r == Q4 && state_r == EXEC_FIRST && op_r == OP_MULL
    |=> {prodHigh_r, prodLow_r} == 16'($past(accum_r)) * 16'($past(instr_r[7:0]))
    && $stable(accum_r) && $stable(flags_r)) else $error("literal product wrong");
  literal_load_a: assert property (qPhase_r == Q4 && state_r == EXEC_FIRST
    && op_r == OP_LITACC |=> accum_r == $past(instr_r[7:0])) else $error("literal not loaded");
  no_op_quiet_a: assert property (qPhase_r == Q4 && op_r == OP_NONE
    && state_r == EXEC_FIRST |=> !dataWrEn_r && $stable(accum_r) && $stable(flags_r))
    else $error("no-op changed state");
  stack_push_a: assert property (stackPush_r |->
    stackPushValue_r == 21'($past(progCounter) + PUSH_STEP) && !stackPop_r)
    else $error("push value wrong");
endmodule

// ==== tb/mmso_prog_mem.sv ====
// partner model: program memory handing the core one instruction word per cycle
`timescale 1ns/1ps
module mmso_prog_mem
  import mmso_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [1:0]  qPhase,
  input  wire logic [15:0] progWord,
  output logic      [15:0] instrWord
);
  //////////////////////////////////////////////////////////////////////////////
  // word stands only through the q1 clock; the inverse shows elsewhere so a late
  // sample never matches by luck
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      instrWord <= NO_OPERATION;
    else if (qPhase == Q4)
      instrWord <= progWord;
    else if (qPhase == Q1)
      instrWord <= ~progWord;
  end
endmodule

// ==== tb/tb.sv ====
// testbench: corner and random instruction streams checked against a reference model
`timescale 1ns/1ps
module tb
  import mmso_pkg::*;
();
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] progWord = 16'h0000;
  logic [20:0] progCounter = 21'h000000;
  logic [15:0] instrWord;
  logic [7:0]  dataRdData, dataWrData, accumulator, bankSelect, productHigh, productLow;
  logic [1:0]  qPhase;
  logic [11:0] dataAddr, eAddr;
  logic        dataRdEn, dataWrEn, stackPush, stackPop, eWr, ePush, ePop, movePend;
  logic [4:0]  statusFlags, eFlags;
  logic [20:0] stackPushValue, ePushVal;
  logic [7:0]  mem [4096];
  logic [7:0]  rmem [4096];
  logic [7:0]  eAcc, eBank, eProdH, eProdL, eWrData, srcVal;
  logic [31:0] seed = 32'h2fc9;
  logic [31:0] r;
  logic [15:0] corner [$];
  int          error_cnt = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;

  mmso_prog_mem pm (.clk(clk), .reset_n(reset_n), .qPhase(qPhase), .progWord(progWord),
    .instrWord(instrWord));
  mmso_move_mul_core dut (.clk(clk), .reset_n(reset_n), .instrWord(instrWord),
    .progCounter(progCounter), .dataRdData(dataRdData), .qPhase(qPhase),
    .dataAddr(dataAddr), .dataRdEn(dataRdEn), .dataWrEn(dataWrEn),
    .dataWrData(dataWrData), .accumulator(accumulator), .bankSelect(bankSelect),
    .productHigh(productHigh), .productLow(productLow), .statusFlags(statusFlags),
    .stackPush(stackPush), .stackPop(stackPop), .stackPushValue(stackPushValue));

  //////////////////////////////////////////////////////////////////////////////
  // data memory: combinational read, inverse shown when no read is strobed
  assign dataRdData = dataRdEn ? mem[dataAddr] : ~mem[dataAddr];
  always @(posedge clk)
    if (dataWrEn === 1'b1)
      mem[dataAddr] <= dataWrData;

  //////////////////////////////////////////////////////////////////////////////
  // helpers: random source, comparison, verdict, bounded phase wait
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic chk(input string name, input logic [20:0] seen, input logic [20:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wait_phase(input logic [1:0] ph);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (qPhase !== ph && n < 8);
    if (qPhase !== ph)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // reference model: addressing, reads through the accumulator, writes, flags
  function automatic logic [11:0] fa(input logic a, input logic [7:0] f);
    if (a)
      return {eBank[3:0], f};
    return (f < ACCESS_SPLIT) ? {ACCESS_LOWPG, f} : {ACCESS_HIPG, f};
  endfunction

  function automatic logic [7:0] rd(input logic [11:0] ad);
    return (ad == ACC_ADDR_DEF) ? eAcc : rmem[ad];
  endfunction

  // accumulator writes land in the register, so no memory strobe is expected
  task automatic wr(input logic [11:0] ad, input logic [7:0] v);
    if (ad == ACC_ADDR_DEF)
      eAcc = v;
    else
    begin
      rmem[ad] = v;
      {eWr, eAddr, eWrData} = {1'b1, ad, v};
    end
  endtask

  // flags in {N,OV,Z,DC,C} order, all taken from the operand and its negation
  function automatic logic [4:0] negFlags(input logic [7:0] v);
    logic [7:0] n;
    n = 8'h00 - v;
    return {n[7], v == 8'h80, n == 8'h00, v[3:0] == 4'h0, v == 8'h00};
  endfunction

  task automatic check_all();
    chk("accumulator", 21'(accumulator), 21'(eAcc));
    chk("bankSelect", 21'(bankSelect), 21'(eBank));
    chk("product", 21'({productHigh, productLow}), 21'({eProdH, eProdL}));
    chk("statusFlags", 21'(statusFlags), 21'(eFlags));
    chk("dataWrEn", 21'(dataWrEn), 21'(eWr));
    if (eWr)
      chk("write", 21'({dataAddr, dataWrData}), 21'({eAddr, eWrData}));
    chk("stackPop", 21'(stackPop), 21'(ePop));
    chk("stackPush", 21'(stackPush), 21'(ePush));
    if (ePush)
      chk("stackPushValue", stackPushValue, ePushVal);
  endtask

  // hand over one word, check the previous word's results, then predict this one
  task automatic step(input logic [15:0] w);
    logic [20:0] pc;
    logic [7:0]  v;
    wait_phase(Q4);
    progWord = w;
    @(negedge clk);
    check_all();
    pc = 21'(rnd());
    {eWr, ePush, ePop} = 3'h0;
    v = rd(fa(w[8], w[7:0]));
    if (movePend)
    begin
      wr(w[11:0], srcVal);
      movePend = 1'b0;
    end
    else if (w[15:12] == MOVE_FIRST_HI)
      {srcVal, movePend} = {rd(w[11:0]), 1'b1};
    else if (w[15:9] == ACC_TO_FILE)
      wr(fa(w[8], w[7:0]), eAcc);
    else if (w[15:9] == NEGATE_FILE)
    begin
      eFlags = negFlags(v);
      wr(fa(w[8], w[7:0]), 8'h00 - v);
    end
    else if (w[15:9] == FILE_MULTIPLY)
      {eProdH, eProdL} = eAcc * v;
    else if (w[15:8] == LIT_MULTIPLY)
      {eProdH, eProdL} = eAcc * w[7:0];
    else if (w[15:8] == LIT_TO_ACC)
      eAcc = w[7:0];
    else if (w[15:8] == BANK_LIT_LOAD)
      eBank = w[7:0];
    else if (w == STACK_POP)
      ePop = 1'b1;
    else if (w == STACK_PUSH)
      {ePush, ePushVal} = {1'b1, pc + PUSH_STEP};
    @(posedge clk);
    progCounter <= pc;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, corner cases, then random traffic
  initial
  begin
    {eAcc, eBank, eProdH, eProdL, eFlags} = {ACC_RST, BANK_RST, PROD_RST, PROD_RST, FLAGS_RST};
    {eWr, ePush, ePop, movePend} = 4'h0;
    for (int i = 0; i < 4096; i++)
    begin
      mem[i] = 8'(rnd());
      rmem[i] = mem[i];
    end
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    // negate edges, access split, top bank, accumulator on both move ends
    corner = {{LIT_TO_ACC, 8'h80}, {NEGATE_FILE, 9'h0e8}, {LIT_TO_ACC, 8'h00},
      {NEGATE_FILE, 9'h0e8}, {BANK_LIT_LOAD, 8'hff}, {ACC_TO_FILE, 9'h1ff},
      {ACC_TO_FILE, 9'h07f}, {ACC_TO_FILE, 9'h080}, {NEGATE_FILE, 9'h07f},
      16'hc000, 16'hffe8, 16'hcfe8, 16'hf000, 16'hcfff, 16'hf7ab,
      16'hf123, NO_OPERATION, STACK_PUSH, STACK_POP, {LIT_TO_ACC, 8'hff},
      {LIT_MULTIPLY, 8'hff}, {FILE_MULTIPLY, 9'h1ff}};
    foreach (corner[i])
      step(corner[i]);
    repeat (400)
    begin
      r = rnd();
      case (r[3:0])
        4'h0: step({LIT_TO_ACC, r[15:8]});
        4'h1: step({BANK_LIT_LOAD, r[15:8]});
        4'h2: step({LIT_MULTIPLY, r[15:8]});
        4'h3: step({FILE_MULTIPLY, r[16:8]});
        4'h4: step({ACC_TO_FILE, r[16:8]});
        4'h5: step({NEGATE_FILE, r[16:8]});
        4'h6: step(STACK_PUSH);
        4'h7: step(STACK_POP);
        4'h8: step({MOVE_SECND_HI, r[27:16]});
        4'h9: step(NO_OPERATION);
        default:
        begin
          step({MOVE_FIRST_HI, r[27:16]});
          // destinations stay below the special page or name the accumulator
          step({MOVE_SECND_HI, r[31] ? ACC_ADDR_DEF : {1'b0, r[26:16]}});
        end
      endcase
    end
    step(NO_OPERATION);
    step(NO_OPERATION);
    wrap_up();
  end
endmodule
